// >>> common/timer8_pkg.sv
// Constants, register map and carrier types for the four-channel 8-bit timer.
// Assumes a 32-bit APB master and a single 125 MHz system clock.
package timer8_pkg;
    localparam int NUM_CH = 4;
    localparam logic [1:0] CH_ZERO = 2'd0;
    localparam logic [1:0] CH_ONE = 2'd1;
    localparam logic [1:0] CH_WHY = 2'd2;
    localparam logic [1:0] CH_EX = 2'd3;
    // Byte addresses; control of Y and X share one slot
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_CTRLYX = 8'h08;
    localparam logic [7:0] ADDR_COUNT0 = 8'h0c;
    localparam logic [7:0] ADDR_COUNT1 = 8'h10;
    localparam logic [7:0] ADDR_COUNTYX = 8'h14;
    localparam logic [7:0] ADDR_CONSTA0 = 8'h18;
    localparam logic [7:0] ADDR_CONSTA1 = 8'h1c;
    localparam logic [7:0] ADDR_CONSTAYX = 8'h20;
    localparam logic [7:0] ADDR_CONSTB0 = 8'h24;
    localparam logic [7:0] ADDR_CONSTB1 = 8'h28;
    localparam logic [7:0] ADDR_CONSTBYX = 8'h2c;
    localparam logic [7:0] ADDR_FLAGS0 = 8'h30;
    localparam logic [7:0] ADDR_FLAGS1 = 8'h34;
    localparam logic [7:0] ADDR_FLAGSYX = 8'h38;
    localparam logic [7:0] ADDR_SERIAL = 8'h3c;
    localparam logic [7:0] ADDR_CONNSEL = 8'h40;
    localparam logic [7:0] ADDR_IRQSTAT = 8'h44;
    localparam logic [7:0] ADDR_IRQMASK = 8'h48;
    localparam logic [31:0] ERR_DATA = 32'h0000_0000;
    // Control field positions
    localparam int B_IEB = 7;
    localparam int B_IEA = 6;
    localparam int B_IEW = 5;
    localparam int B_CLR_HI = 4;
    localparam int B_CLR_LO = 3;
    localparam int B_CKS_HI = 2;
    // Flag positions in the flags register
    localparam int F_MB = 7;
    localparam int F_MA = 6;
    localparam int F_WR = 5;
    localparam logic [7:0] FLAGS_RSVD = 8'h1f;
    // Serial control tap bits, connection select bank bit
    localparam int B_TAP0 = 0;
    localparam int B_TAP1 = 1;
    localparam int B_BANK = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] CONST_RST = 8'hff;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    // Clock-select codes
    localparam logic [2:0] CKS_STOP = 3'b000;
    localparam logic [2:0] CKS_T1 = 3'b001;
    localparam logic [2:0] CKS_T2 = 3'b010;
    localparam logic [2:0] CKS_T3 = 3'b011;
    localparam logic [2:0] CKS_CASC = 3'b100;
    // Clear-select codes
    localparam logic [1:0] CLR_NONE = 2'b00;
    localparam logic [1:0] CLR_MA = 2'b01;
    localparam logic [1:0] CLR_MB = 2'b10;
    // Prescaler tap indices: phi/2^n uses bit n-1 of the prescaler
    localparam int PRE_W = 11;
    localparam int T_D2 = 0;
    localparam int T_D4 = 1;
    localparam int T_D8 = 2;
    localparam int T_D32 = 4;
    localparam int T_D64 = 5;
    localparam int T_D128 = 6;
    localparam int T_D256 = 7;
    localparam int T_D1024 = 9;
    localparam int T_D2048 = 10;
    // Interrupt status bit groups: 3 bits per channel (B,A,wrap)
    localparam int IRQ_W = 12;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] count;
        logic [7:0] constA;
        logic [7:0] constB;
        logic [2:0] flags;
    } chan_s;

    typedef struct packed {
        logic matchB;
        logic matchA;
        logic wrap;
    } irq_s;
endpackage

// >>> rtl/timer8_control_clock_select.sv
// Four 8-bit timer channels with control, clock selection and an APB slave.
// Assumes APB is synchronous to clk_sys; the prescaler runs from clk_sys.
//
// Function
// - Control bit 7 enables the match-B interrupt while the match-B flag is set.
// - Control bit 6 enables the match-A interrupt while the match-A flag is set.
// - Control bit 5 enables the wrap interrupt while the wrap flag is set.
// - Clear field: 00 never, 01 on match A, 10 on match B; 11 forbidden.
// - Clock-select and the channel tap bit jointly choose the count source of channels zero and one.
// - Channel zero taps phi/8,64,1024 or phi/2,32,256 by its tap bit.
// - Channel one taps phi/8,64,1024 or phi/2,128,2048 by its tap bit.
// - Select 100 makes channel zero count channel one overflows.
// - Select 100 makes channel one count channel zero match-A events.
// - Channel why taps phi/4, phi/256, phi/2048; select 100 forbidden.
// - Channel ex counts phi, phi/2, phi/4 for 001, 010, 011; 100 forbidden.
// - Bank bit 1 reaches channel why registers, 0 reaches channel ex.
// - Wrap flag sets when the counter passes from ff to 00.
// - Counter compared with both constants; equality sets the matching flag.
`timescale 1ns/1ps
`default_nettype none
module timer8_control_clock_select (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [timer8_pkg::IRQ_W-1:0] chanIrq,
    output logic irq
);
    timer8_pkg::chan_s ch_q [timer8_pkg::NUM_CH];
    timer8_pkg::chan_s ch_d [timer8_pkg::NUM_CH];
    logic [timer8_pkg::PRE_W-1:0] pre_q, pre_d;
    logic [timer8_pkg::NUM_CH-1:0] tap_q, tap_d;
    logic prevMatchA_q, prevMatchA_d;
    logic [7:0] serial_q, serial_d, connSel_q, connSel_d;
    logic [timer8_pkg::IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d, irq_d;
    logic [timer8_pkg::IRQ_W-1:0] chanIrq_d;
    logic [timer8_pkg::NUM_CH-1:0] tapNow, inc, matchA, matchB, wrapEv;
    logic access, wr, rdErr;
    logic [1:0] yx;

    // Tap level picked for a channel; stop or forbidden code gives a steady low
    function automatic logic tapSel(input logic [1:0] ch, input logic [2:0] cks, input logic tap,
                                    input logic [timer8_pkg::PRE_W-1:0] pre);
        logic v;
        v = 1'b0;
        unique case (ch)
            timer8_pkg::CH_ZERO: begin
                if (cks == timer8_pkg::CKS_T1) v = tap ? pre[timer8_pkg::T_D2] : pre[timer8_pkg::T_D8];
                if (cks == timer8_pkg::CKS_T2) v = tap ? pre[timer8_pkg::T_D32] : pre[timer8_pkg::T_D64];
                if (cks == timer8_pkg::CKS_T3) v = tap ? pre[timer8_pkg::T_D256] : pre[timer8_pkg::T_D1024];
            end
            timer8_pkg::CH_ONE: begin
                if (cks == timer8_pkg::CKS_T1) v = tap ? pre[timer8_pkg::T_D2] : pre[timer8_pkg::T_D8];
                if (cks == timer8_pkg::CKS_T2) v = tap ? pre[timer8_pkg::T_D128] : pre[timer8_pkg::T_D64];
                if (cks == timer8_pkg::CKS_T3) v = tap ? pre[timer8_pkg::T_D2048] : pre[timer8_pkg::T_D1024];
            end
            timer8_pkg::CH_WHY: begin
                if (cks == timer8_pkg::CKS_T1) v = pre[timer8_pkg::T_D4];
                if (cks == timer8_pkg::CKS_T2) v = pre[timer8_pkg::T_D256];
                if (cks == timer8_pkg::CKS_T3) v = pre[timer8_pkg::T_D2048];
            end
            timer8_pkg::CH_EX: begin
                if (cks == timer8_pkg::CKS_T2) v = pre[timer8_pkg::T_D2];
                if (cks == timer8_pkg::CKS_T3) v = pre[timer8_pkg::T_D4];
            end
        endcase
        return v;
    endfunction

    // Register byte of a channel as software reads it
    function automatic logic [7:0] flagByte(input logic [2:0] f);
        return {f, timer8_pkg::FLAGS_RSVD[4:0]};
    endfunction

    assign access = psel && penable;
    assign wr = access && pwrite;
    assign yx = connSel_q[timer8_pkg::B_BANK] ? timer8_pkg::CH_WHY : timer8_pkg::CH_EX;

    always_comb begin
        logic [2:0] cks;
        logic [1:0] clr;
        logic [1:0] idx;
        logic [7:0] nxt;
        cks = '0;
        clr = '0;
        idx = '0;
        nxt = '0;
        pre_d = pre_q + 1'b1;
        serial_d = serial_q;
        connSel_d = connSel_q;
        mask_d = mask_q;
        stat_d = stat_q;
        tapNow = '0;
        inc = '0;
        matchA = '0;
        matchB = '0;
        wrapEv = '0;
        for (int i = 0; i < timer8_pkg::NUM_CH; i++) begin
            idx = 2'(i);
            ch_d[i] = ch_q[i];
            tapNow[i] = tapSel(idx, ch_q[i].ctrl[timer8_pkg::B_CKS_HI:0],
                               (i == 0) ? serial_q[timer8_pkg::B_TAP0] : serial_q[timer8_pkg::B_TAP1], pre_q);
            matchA[i] = ch_q[i].count == ch_q[i].constA;
            matchB[i] = ch_q[i].count == ch_q[i].constB;
        end
        tap_d = tapNow;
        prevMatchA_d = matchA[0];
        for (int i = 0; i < timer8_pkg::NUM_CH; i++) begin
            cks = ch_q[i].ctrl[timer8_pkg::B_CKS_HI:0];
            // Leaving a high tap for stop would read as a falling edge; halted selections never count
            inc[i] = tap_q[i] && !tapNow[i] && cks != timer8_pkg::CKS_STOP && cks < timer8_pkg::CKS_CASC;
            // Ex counts every system clock when undivided is chosen
            if (i == timer8_pkg::CH_EX && cks == timer8_pkg::CKS_T1) inc[i] = 1'b1;
        end
        // Cascade sources use the same cycle's events of the partner channel
        // One count per match event, even while channel zero rests on its constant
        if (ch_q[1].ctrl[timer8_pkg::B_CKS_HI:0] == timer8_pkg::CKS_CASC) begin
            inc[1] = matchA[0] && !prevMatchA_q;
        end
        wrapEv[1] = inc[1] && ch_q[1].count == timer8_pkg::COUNT_MAX;
        if (ch_q[0].ctrl[timer8_pkg::B_CKS_HI:0] == timer8_pkg::CKS_CASC) inc[0] = wrapEv[1];
        wrapEv[0] = inc[0] && ch_q[0].count == timer8_pkg::COUNT_MAX;
        for (int i = 2; i < timer8_pkg::NUM_CH; i++) begin
            wrapEv[i] = inc[i] && ch_q[i].count == timer8_pkg::COUNT_MAX;
        end
        for (int i = 0; i < timer8_pkg::NUM_CH; i++) begin
            clr = ch_q[i].ctrl[timer8_pkg::B_CLR_HI:timer8_pkg::B_CLR_LO];
            nxt = ch_q[i].count + 8'(inc[i]);
            if ((clr == timer8_pkg::CLR_MA && matchA[i]) || (clr == timer8_pkg::CLR_MB && matchB[i])) begin
                nxt = timer8_pkg::COUNT_RST;
            end
            ch_d[i].count = nxt;
        end
        // Software writes; flags clear by writing 0, a same-cycle set wins
        if (wr) begin
            idx = 2'd0;
            unique case (paddr)
                timer8_pkg::ADDR_CTRL0, timer8_pkg::ADDR_COUNT0, timer8_pkg::ADDR_CONSTA0,
                timer8_pkg::ADDR_CONSTB0, timer8_pkg::ADDR_FLAGS0: idx = timer8_pkg::CH_ZERO;
                timer8_pkg::ADDR_CTRL1, timer8_pkg::ADDR_COUNT1, timer8_pkg::ADDR_CONSTA1,
                timer8_pkg::ADDR_CONSTB1, timer8_pkg::ADDR_FLAGS1: idx = timer8_pkg::CH_ONE;
                default: idx = yx;
            endcase
            unique case (paddr)
                timer8_pkg::ADDR_CTRL0, timer8_pkg::ADDR_CTRL1, timer8_pkg::ADDR_CTRLYX:
                    ch_d[idx].ctrl = pwdata[7:0];
                timer8_pkg::ADDR_COUNT0, timer8_pkg::ADDR_COUNT1, timer8_pkg::ADDR_COUNTYX:
                    ch_d[idx].count = pwdata[7:0];
                timer8_pkg::ADDR_CONSTA0, timer8_pkg::ADDR_CONSTA1, timer8_pkg::ADDR_CONSTAYX:
                    ch_d[idx].constA = pwdata[7:0];
                timer8_pkg::ADDR_CONSTB0, timer8_pkg::ADDR_CONSTB1, timer8_pkg::ADDR_CONSTBYX:
                    ch_d[idx].constB = pwdata[7:0];
                timer8_pkg::ADDR_FLAGS0, timer8_pkg::ADDR_FLAGS1, timer8_pkg::ADDR_FLAGSYX:
                    ch_d[idx].flags = ch_q[idx].flags & pwdata[timer8_pkg::F_MB:timer8_pkg::F_WR];
                timer8_pkg::ADDR_SERIAL: serial_d = pwdata[7:0];
                timer8_pkg::ADDR_CONNSEL: connSel_d = pwdata[7:0];
                timer8_pkg::ADDR_IRQSTAT: stat_d = stat_q & ~pwdata[timer8_pkg::IRQ_W-1:0];
                timer8_pkg::ADDR_IRQMASK: mask_d = pwdata[timer8_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
        for (int i = 0; i < timer8_pkg::NUM_CH; i++) begin
            ch_d[i].flags = ch_d[i].flags | {matchB[i], matchA[i], wrapEv[i]};
            stat_d[3*i +: 3] = stat_d[3*i +: 3] | {matchB[i], matchA[i], wrapEv[i]};
            chanIrq_d[3*i+2] = ch_d[i].flags[2] && ch_d[i].ctrl[timer8_pkg::B_IEB];
            chanIrq_d[3*i+1] = ch_d[i].flags[1] && ch_d[i].ctrl[timer8_pkg::B_IEA];
            chanIrq_d[3*i] = ch_d[i].flags[0] && ch_d[i].ctrl[timer8_pkg::B_IEW];
        end
        irq_d = |(stat_d & mask_d);
    end

    // Read path and bus answer; every access completes in its second access cycle
    always_comb begin
        prdata_d = timer8_pkg::ERR_DATA;
        rdErr = 1'b0;
        unique case (paddr)
            timer8_pkg::ADDR_CTRL0: prdata_d[7:0] = ch_q[0].ctrl;
            timer8_pkg::ADDR_CTRL1: prdata_d[7:0] = ch_q[1].ctrl;
            timer8_pkg::ADDR_CTRLYX: prdata_d[7:0] = ch_q[yx].ctrl;
            timer8_pkg::ADDR_COUNT0: prdata_d[7:0] = ch_q[0].count;
            timer8_pkg::ADDR_COUNT1: prdata_d[7:0] = ch_q[1].count;
            timer8_pkg::ADDR_COUNTYX: prdata_d[7:0] = ch_q[yx].count;
            timer8_pkg::ADDR_CONSTA0: prdata_d[7:0] = ch_q[0].constA;
            timer8_pkg::ADDR_CONSTA1: prdata_d[7:0] = ch_q[1].constA;
            timer8_pkg::ADDR_CONSTAYX: prdata_d[7:0] = ch_q[yx].constA;
            timer8_pkg::ADDR_CONSTB0: prdata_d[7:0] = ch_q[0].constB;
            timer8_pkg::ADDR_CONSTB1: prdata_d[7:0] = ch_q[1].constB;
            timer8_pkg::ADDR_CONSTBYX: prdata_d[7:0] = ch_q[yx].constB;
            timer8_pkg::ADDR_FLAGS0: prdata_d[7:0] = flagByte(ch_q[0].flags);
            timer8_pkg::ADDR_FLAGS1: prdata_d[7:0] = flagByte(ch_q[1].flags);
            timer8_pkg::ADDR_FLAGSYX: prdata_d[7:0] = flagByte(ch_q[yx].flags);
            timer8_pkg::ADDR_SERIAL: prdata_d[7:0] = serial_q;
            timer8_pkg::ADDR_CONNSEL: prdata_d[7:0] = connSel_q;
            timer8_pkg::ADDR_IRQSTAT: prdata_d[timer8_pkg::IRQ_W-1:0] = stat_q;
            timer8_pkg::ADDR_IRQMASK: prdata_d[timer8_pkg::IRQ_W-1:0] = mask_q;
            default: rdErr = 1'b1;
        endcase
        // Ready is registered, so it rises one cycle into the access phase
        pready_d = access && !pready;
        pslverr_d = access && !pready && rdErr;
        if (!(access && !pready && !pwrite)) prdata_d = timer8_pkg::ERR_DATA;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < timer8_pkg::NUM_CH; i++) begin
                ch_q[i] <= '{timer8_pkg::CTRL_RST, timer8_pkg::COUNT_RST, timer8_pkg::CONST_RST,
                             timer8_pkg::CONST_RST, 3'b000};
            end
            pre_q <= '0;
            tap_q <= '0;
            prevMatchA_q <= 1'b0;
            serial_q <= 8'h00;
            connSel_q <= 8'h00;
            stat_q <= '0;
            mask_q <= '0;
            prdata <= timer8_pkg::ERR_DATA;
            pready <= 1'b0;
            pslverr <= 1'b0;
            chanIrq <= '0;
            irq <= 1'b0;
        end else begin
            // Writes land at the taking edge, the same edge that raises ready, and land again at the ready edge
            for (int i = 0; i < timer8_pkg::NUM_CH; i++) begin
                ch_q[i] <= ch_d[i];
            end
            pre_q <= pre_d;
            tap_q <= tap_d;
            prevMatchA_q <= prevMatchA_d;
            serial_q <= serial_d;
            connSel_q <= connSel_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
            chanIrq <= chanIrq_d;
            irq <= irq_d;
        end
    end
endmodule
`default_nettype wire

// >>> verification/timer8_control_clock_select_sva.sv
// Port-level checks for the four-channel 8-bit timer.
// Assumes one clk_sys domain and the active-high asynchronous rst.
`timescale 1ns/1ps
`default_nettype none
module timer8_ctrl_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [timer8_pkg::IRQ_W-1:0] chanIrq,
    input wire logic irq
);
    logic take;
    logic wrTake;
    logic badAddr;
    assign take = psel && penable && !pready;
    assign wrTake = take && pwrite;
    assign badAddr = (paddr > timer8_pkg::ADDR_IRQMASK) || (paddr[1:0] != 2'b00);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    answer_time_a: assert property (take |=> pready) else $error("access not answered");
    pready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    ready_cause_a: assert property ($rose(pready) |-> $past(psel && penable)) else $error("ready without access");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    rdata_quiet_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0) else $error("read data not zero");
    unmapped_err_a: assert property (take && badAddr |=> pslverr) else $error("unmapped access not refused");
    mapped_ok_a: assert property (take && !badAddr |=> !pslverr) else $error("mapped access refused");
    mask_gate_a: assert property (wrTake && paddr == timer8_pkg::ADDR_IRQMASK && pwdata[11:0] == 12'h000
        |-> ##[2:3] !irq) else $error("masked irq still high");
    zero_gate_a: assert property (wrTake && paddr == timer8_pkg::ADDR_CTRL0 && pwdata[7:5] == 3'b000
        |-> ##[2:3] chanIrq[2:0] == 3'b000) else $error("channel zero irq not gated");
    one_gate_a: assert property (wrTake && paddr == timer8_pkg::ADDR_CTRL1 && pwdata[7:5] == 3'b000
        |-> ##[2:3] chanIrq[5:3] == 3'b000) else $error("channel one irq not gated");
    cover property (wrTake);
    cover property (take && !pwrite);
    cover property (pslverr);
    cover property (irq);
endmodule
bind timer8_control_clock_select timer8_ctrl_checker chk (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chanIrq(chanIrq), .irq(irq));
`default_nettype wire

// >>> verification/timer8_control_clock_select_tb.sv
// Self-checking bench for the four-channel 8-bit timer over APB.
// Assumes the checker is bound to the design; counts are read back after stopping.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin errTotal++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module timer8_control_clock_select_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [timer8_pkg::IRQ_W-1:0] chanIrq;
    logic irq;
    logic [31:0] rv;
    logic re;
    int errTotal = 0;
    int cmpCount = 0;
    int div0 [6] = '{8, 64, 1024, 2, 32, 256};
    int div1 [6] = '{8, 64, 1024, 2, 128, 2048};
    int divY [3] = '{4, 256, 2048};
    int divX [3] = '{1, 2, 4};
    timer8_control_clock_select dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chanIrq(chanIrq), .irq(irq));
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // No wait-state count is assumed; only the watchdog ends a hung access
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rv, re);
        `CHK(re, 1'b0)
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, rv, re);
        `CHK(rv, e)
        `CHK(re, 1'b0)
    endtask
    // Write-to-write effect spacing is gap cycles; edge phase allows a slack of two counts
    task automatic meas(input logic [7:0] ca, input logic [7:0] na, input logic [7:0] cv, input int gap,
                        input logic [7:0] e);
        wr(na, 32'h0);
        wr(ca, {24'h0, cv});
        repeat (gap - 4) @(posedge clk_sys);
        wr(ca, {24'h0, cv & 8'hf8});
        apb(1'b0, na, 32'h0, rv, re);
        `CHK(rv[7:0] - e + 8'h02 <= 8'h04, 1'b1)
    endtask
    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk_sys);
        errTotal++;
        wrapUp();
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        `CHK({chanIrq, irq}, 13'h0000)
        rdchk(timer8_pkg::ADDR_CTRL0, 32'h00);
        rdchk(timer8_pkg::ADDR_COUNT0, 32'h00);
        rdchk(timer8_pkg::ADDR_CONSTA0, 32'hff);
        rdchk(timer8_pkg::ADDR_CONSTB1, 32'hff);
        rdchk(timer8_pkg::ADDR_FLAGS0, 32'h1f);
        apb(1'b1, 8'h4c, 32'h5a, rv, re);
        `CHK(re, 1'b1)
        apb(1'b0, 8'h4c, 32'h0, rv, re);
        `CHK({rv, re}, 33'h1)
        wr(timer8_pkg::ADDR_CONNSEL, 32'h80);
        wr(timer8_pkg::ADDR_CTRLYX, 32'h21);
        wr(timer8_pkg::ADDR_CONNSEL, 32'h00);
        wr(timer8_pkg::ADDR_CTRLYX, 32'h42);
        rdchk(timer8_pkg::ADDR_CTRLYX, 32'h42);
        wr(timer8_pkg::ADDR_CONNSEL, 32'h80);
        rdchk(timer8_pkg::ADDR_CTRLYX, 32'h21);
        for (int i = 0; i < 6; i++) begin
            wr(timer8_pkg::ADDR_SERIAL, (i < 3) ? 32'h0 : 32'h3);
            meas(timer8_pkg::ADDR_CTRL0, timer8_pkg::ADDR_COUNT0, 8'(i % 3 + 1), 10 * div0[i], 8'd10);
            meas(timer8_pkg::ADDR_CTRL1, timer8_pkg::ADDR_COUNT1, 8'(i % 3 + 1), 10 * div1[i], 8'd10);
        end
        for (int i = 0; i < 3; i++) begin
            meas(timer8_pkg::ADDR_CTRLYX, timer8_pkg::ADDR_COUNTYX, 8'(i + 1), 10 * divY[i], 8'd10);
        end
        wr(timer8_pkg::ADDR_CONNSEL, 32'h00);
        for (int i = 0; i < 3; i++) begin
            meas(timer8_pkg::ADDR_CTRLYX, timer8_pkg::ADDR_COUNTYX, 8'(i + 1), 10 * divX[i], 8'd10);
        end
        for (int i = 0; i < 2; i++) begin
            wr(timer8_pkg::ADDR_COUNT1, 32'h0);
            wr(timer8_pkg::ADDR_CTRL1, i ? 32'he0 : 32'h00);
            repeat (300) @(posedge clk_sys);
            rdchk(timer8_pkg::ADDR_COUNT1, 32'h00);
        end
        // Channel zero on phi/2: fold at 3 gives a match every 6 cycles, fold at 5 every 10; code 11 unused
        wr(timer8_pkg::ADDR_CONSTA0, 32'h03);
        wr(timer8_pkg::ADDR_CONSTB0, 32'h05);
        wr(timer8_pkg::ADDR_COUNT0, 32'h0);
        for (int k = 0; k < 3; k++) begin
            wr(timer8_pkg::ADDR_CTRL0, {27'h0, (k < 2) ? 2'(k + 1) : timer8_pkg::CLR_NONE, 3'b001});
            meas(timer8_pkg::ADDR_CTRL1, timer8_pkg::ADDR_COUNT1, 8'h04, 60,
                 (k == 0) ? 8'd10 : (k == 1) ? 8'd6 : 8'd0);
        end
        wr(timer8_pkg::ADDR_CTRL0, 32'h00);
        wr(timer8_pkg::ADDR_COUNT1, 32'h0);
        wr(timer8_pkg::ADDR_CTRL1, 32'h01);
        meas(timer8_pkg::ADDR_CTRL0, timer8_pkg::ADDR_COUNT0, 8'h04, 3072, 8'd6);
        wr(timer8_pkg::ADDR_CTRL1, 32'h00);
        wr(timer8_pkg::ADDR_CONSTA0, 32'h10);
        wr(timer8_pkg::ADDR_CONSTB0, 32'h40);
        wr(timer8_pkg::ADDR_COUNT0, 32'h0);
        wr(timer8_pkg::ADDR_FLAGS0, 32'h0);
        wr(timer8_pkg::ADDR_IRQSTAT, 32'hfff);
        meas(timer8_pkg::ADDR_CTRL0, timer8_pkg::ADDR_COUNT0, 8'he1, 80, 8'h28);
        rdchk(timer8_pkg::ADDR_FLAGS0, 32'h5f);
        `CHK({chanIrq, irq}, 13'h0004)
        wr(timer8_pkg::ADDR_CTRL0, 32'he1);
        repeat (600) @(posedge clk_sys);
        wr(timer8_pkg::ADDR_CTRL0, 32'ha0);
        rdchk(timer8_pkg::ADDR_FLAGS0, 32'hff);
        repeat (3) @(posedge clk_sys);
        `CHK(chanIrq, 12'h005)
        wr(timer8_pkg::ADDR_IRQMASK, 32'h1);
        repeat (3) @(posedge clk_sys);
        `CHK(irq, 1'b1)
        rdchk(timer8_pkg::ADDR_IRQSTAT, 32'h7);
        wr(timer8_pkg::ADDR_IRQSTAT, 32'h1);
        rdchk(timer8_pkg::ADDR_IRQSTAT, 32'h6);
        `CHK(irq, 1'b0)
        wr(timer8_pkg::ADDR_IRQMASK, 32'h6);
        repeat (3) @(posedge clk_sys);
        `CHK(irq, 1'b1)
        wr(timer8_pkg::ADDR_IRQMASK, 32'h0);
        wr(timer8_pkg::ADDR_FLAGS0, 32'h0);
        rdchk(timer8_pkg::ADDR_FLAGS0, 32'h1f);
        `CHK({chanIrq, irq}, 13'h0000)
        wrapUp();
    end
endmodule
`undef CHK
`default_nettype wire
